// >>> include/cbq_pkg.sv
package cbq_pkg;

  // ----------------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CONFIG  = 8'h04;
  localparam logic [7:0] ADDR_TRIGPOS = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_WRPTR   = 8'h10;
  localparam logic [7:0] ADDR_TRIGPTR = 8'h14;
  localparam logic [7:0] ADDR_SEGIDX  = 8'h18;
  localparam logic [7:0] ADDR_INSPECT = 8'h1C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ARM_BIT     = 0;
  localparam int CTRL_ABORT_BIT   = 1;
  localparam int CFG_SEG_EN_BIT   = 0;
  localparam int CFG_DISC_EN_BIT  = 1;
  localparam int CFG_QUAL_LSB     = 4;
  localparam int CFG_QUAL_W       = 3;
  localparam int CFG_SEGLOG_LSB   = 8;
  localparam int CFG_SEGLOG_W     = 4;
  localparam int TPOS_LSB         = 0;
  localparam int TPOS_W           = 2;

  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] TPOS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // qualifier types: six choices, continuous is the reset value
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    QUAL_CONTINUOUS   = 3'h0,
    QUAL_INPUT_PORT   = 3'h1,
    QUAL_TRANSITIONAL = 3'h2,
    QUAL_CONDITIONAL  = 3'h3,
    QUAL_START_STOP   = 3'h4,
    QUAL_STATE_BASED  = 3'h5
  } cbq_qual_t;

  // trigger positions
  typedef enum logic [1:0] {
    TPOS_PRE    = 2'h0,
    TPOS_CENTER = 2'h1,
    TPOS_POST   = 2'h2
  } cbq_tpos_t;

  // acquisition states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PRE  = 4'h2,
    ST_POST = 4'h4,
    ST_DONE = 4'h8
  } cbq_state_t;

  // classic wishbone slave request and answer
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } cbq_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cbq_wb_rsp_t;

endpackage

// >>> design/cbq_capture.sv
// ------------------------------------------------------------------------
// Notes on behaviour
// ------------------------------------------------------------------------
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cbq_capture #(
  parameter int DATA_W    = 32,
  parameter int ADDR_W    = 12,
  parameter bit CORE_FLOW = 1'b0
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire cbq_pkg::cbq_wb_req_t wb_req_i,
  output var  cbq_pkg::cbq_wb_rsp_t wb_rsp_o,
  // observed design, same clock
  input  wire logic [DATA_W-1:0]    sample_i,
  input  wire logic                 trigger_i,
  input  wire logic                 qual_i,
  // capture memory write port
  output logic                      mem_we_o,
  output logic [ADDR_W-1:0]         mem_addr_o,
  output logic [DATA_W:0]           mem_data_o,
  // status
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      seg_trig_o
);

  // ----------------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W:0] DEPTH = (ADDR_W+1)'(1) << ADDR_W;
  // shares of a segment kept after the trigger, as right shifts
  localparam int          SHARE_EIGHTH_SH = 3;
  localparam int          SHARE_HALF_SH   = 1;
  localparam logic [27:0] STATUS_PAD      = 28'h0000000;


  logic [31:0]          cfg;
  logic [31:0]          tpos_reg;
  logic [DATA_W-1:0]    inspect_mask;
  cbq_pkg::cbq_state_t  state;
  logic [ADDR_W-1:0]    wr_off;
  logic [ADDR_W-1:0]    trig_addr;
  logic [ADDR_W:0]      fill_cnt;
  logic [ADDR_W:0]      post_cnt;
  logic [ADDR_W-1:0]    seg_base;
  logic [ADDR_W-1:0]    seg_idx;
  logic [DATA_W-1:0]    prev_sample;
  logic                 paused;
  logic                 wb_hit;
  logic                 arm_req;
  logic                 abort_req;

  wire logic                seg_en  = cfg[cbq_pkg::CFG_SEG_EN_BIT];
  wire logic                disc_en = cfg[cbq_pkg::CFG_DISC_EN_BIT];
  wire logic [2:0]          qual_sel = cfg[cbq_pkg::CFG_QUAL_LSB +:
                                           cbq_pkg::CFG_QUAL_W];
  wire logic [3:0]          seg_log = cfg[cbq_pkg::CFG_SEGLOG_LSB +:
                                          cbq_pkg::CFG_SEGLOG_W];
  wire logic [1:0]          tpos = tpos_reg[cbq_pkg::TPOS_LSB +:
                                            cbq_pkg::TPOS_W];

  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;

  // read data is picked here and registered together with ack
  logic [31:0] next_rd_dat;
  always_comb begin
    next_rd_dat = '0;
    case (wb_req_i.adr)
      cbq_pkg::ADDR_CONFIG:  next_rd_dat = cfg;
      cbq_pkg::ADDR_TRIGPOS: next_rd_dat = tpos_reg;
      cbq_pkg::ADDR_STATUS:  next_rd_dat = {STATUS_PAD, state};
      cbq_pkg::ADDR_WRPTR:   next_rd_dat = 32'(wr_off);
      cbq_pkg::ADDR_TRIGPTR: next_rd_dat = 32'(trig_addr);
      cbq_pkg::ADDR_SEGIDX:  next_rd_dat = 32'(seg_idx);
      cbq_pkg::ADDR_INSPECT: next_rd_dat = 32'(inspect_mask);
      default:               next_rd_dat = '0;
    endcase
  end

  // single wait-state answer: ack one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '0;
    end else begin
      wb_rsp_o.ack <= wb_hit;
      wb_rsp_o.dat <= '0;
      if (wb_hit && !wb_req_i.we) begin
        wb_rsp_o.dat <= next_rd_dat;
      end
    end
  end

  // configuration writes, ignored while an acquisition runs
  // busy_o lags the arm by one cycle; the idle bus cycle covers it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg          <= cbq_pkg::CFG_RESET;
      tpos_reg     <= cbq_pkg::TPOS_RESET;
      inspect_mask <= '0;
    end else if (wb_hit && wb_req_i.we && !busy_o) begin
      case (wb_req_i.adr)
        cbq_pkg::ADDR_CONFIG: begin
          cfg <= wb_req_i.dat;
          if (CORE_FLOW && wb_req_i.dat[cbq_pkg::CFG_QUAL_LSB +:
              cbq_pkg::CFG_QUAL_W] != 3'(cbq_pkg::QUAL_CONTINUOUS)) begin
            cfg[cbq_pkg::CFG_QUAL_LSB +: cbq_pkg::CFG_QUAL_W] <=
              3'(cbq_pkg::QUAL_INPUT_PORT);
          end
        end
        cbq_pkg::ADDR_TRIGPOS: tpos_reg <= wb_req_i.dat;
        cbq_pkg::ADDR_INSPECT: inspect_mask <= wb_req_i.dat[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  assign arm_req = wb_hit && wb_req_i.we &&
                   wb_req_i.adr == cbq_pkg::ADDR_CTRL &&
                   wb_req_i.dat[cbq_pkg::CTRL_ARM_BIT];
  assign abort_req = wb_hit && wb_req_i.we &&
                     wb_req_i.adr == cbq_pkg::ADDR_CTRL &&
                     wb_req_i.dat[cbq_pkg::CTRL_ABORT_BIT];

  // ----------------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------------
  logic [ADDR_W:0]   seg_len;
  logic [ADDR_W:0]   seg_cnt;
  logic [ADDR_W:0]   post_len;
  logic [ADDR_W-1:0] seg_mask;
  logic [3:0]        seg_log_eff;

  // segment count limit
  // a count above the depth would leave zero-length segments, so it is
  // held to one word per segment instead
  always_comb begin
    if (32'(seg_log) > ADDR_W) begin
      seg_log_eff = 4'(ADDR_W);
    end else begin
      seg_log_eff = seg_log;
    end
  end

  always_comb begin
    if (seg_en) begin
      seg_len = DEPTH >> seg_log_eff;
      seg_cnt = (ADDR_W+1)'(1) << seg_log_eff;
    end else begin
      seg_len = DEPTH;
      seg_cnt = (ADDR_W+1)'(1);
    end
    seg_mask = ADDR_W'(seg_len - (ADDR_W+1)'(1));
    case (tpos)
      2'(cbq_pkg::TPOS_PRE):
        post_len = seg_len - (seg_len >> SHARE_EIGHTH_SH);
      2'(cbq_pkg::TPOS_CENTER): post_len = seg_len >> SHARE_HALF_SH;
      2'(cbq_pkg::TPOS_POST):   post_len = seg_len >> SHARE_EIGHTH_SH;
      default:                  post_len = seg_len >> SHARE_HALF_SH;
    endcase
  end

  // ----------------------------------------------------------------------
  // storage qualifier
  // ----------------------------------------------------------------------
  logic store;
  always_comb begin
    case (qual_sel)
      3'(cbq_pkg::QUAL_INPUT_PORT):
        store = qual_i;
      3'(cbq_pkg::QUAL_TRANSITIONAL):
        store = |((sample_i ^ prev_sample) & inspect_mask);
      default:
        store = 1'b1;
    endcase
    if (seg_en) begin
      store = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // acquisition state machine
  // ----------------------------------------------------------------------
  logic acq;
  logic last_seg;
  assign acq      = (state == cbq_pkg::ST_PRE) || (state == cbq_pkg::ST_POST);
  assign last_seg = (ADDR_W+1)'(seg_idx) == seg_cnt - (ADDR_W+1)'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= cbq_pkg::ST_IDLE;
      wr_off     <= '0;
      fill_cnt   <= '0;
      post_cnt   <= '0;
      trig_addr  <= '0;
      seg_base   <= '0;
      seg_idx    <= '0;
      seg_trig_o <= 1'b0;
    end else begin
      seg_trig_o <= 1'b0;
      case (state)
        cbq_pkg::ST_IDLE, cbq_pkg::ST_DONE: begin
          if (arm_req) begin
            state    <= cbq_pkg::ST_PRE;
            wr_off   <= '0;
            fill_cnt <= '0;
            seg_base <= '0;
            seg_idx  <= '0;
          end
        end
        cbq_pkg::ST_PRE: begin
          if (store) begin
            wr_off <= (wr_off + ADDR_W'(1)) & seg_mask;
            // fill count saturates at the segment length
            if (fill_cnt != seg_len) begin
              fill_cnt <= fill_cnt + (ADDR_W+1)'(1);
            end
          end
          // trigger seen even when not stored
          if (trigger_i) begin
            state      <= cbq_pkg::ST_POST;
            trig_addr  <= seg_base | wr_off;
            seg_trig_o <= 1'b1;
            post_cnt   <= post_len;
          end
        end
        cbq_pkg::ST_POST: begin
          if (store && post_cnt != '0) begin
            wr_off   <= (wr_off + ADDR_W'(1)) & seg_mask;
            post_cnt <= post_cnt - (ADDR_W+1)'(1);
          end
          if (post_cnt == '0 || (store && post_cnt == (ADDR_W+1)'(1))) begin
            if (seg_en && !last_seg) begin
              state    <= cbq_pkg::ST_PRE;
              seg_idx  <= seg_idx + ADDR_W'(1);
              seg_base <= seg_base + ADDR_W'(seg_len);
              wr_off   <= '0;
              fill_cnt <= '0;
            end else begin
              state <= cbq_pkg::ST_DONE;
            end
          end
        end
        default: state <= cbq_pkg::ST_IDLE;
      endcase
      if (abort_req) begin
        state <= cbq_pkg::ST_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // memory write port and discontinuity mark
  // ----------------------------------------------------------------------
  logic writing;
  assign writing = store && (state == cbq_pkg::ST_PRE ||
                   (state == cbq_pkg::ST_POST && post_cnt != '0));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_sample <= '0;
      paused      <= 1'b0;
    end else begin
      prev_sample <= sample_i;
      // a gap before arming must not mark the first stored sample
      if (!acq) begin
        paused <= 1'b0;
      end else begin
        paused <= !writing;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_o   <= 1'b0;
      mem_addr_o <= '0;
      mem_data_o <= '0;
    end else begin
      // write at segment base plus offset
      mem_we_o   <= writing;
      mem_addr_o <= seg_base | wr_off;
      mem_data_o <= {disc_en && paused, sample_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= acq;
      done_o <= (state == cbq_pkg::ST_DONE);
    end
  end

endmodule // cbq_capture

`default_nettype wire

// >>> sim/cbq_capture_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cbq_capture_assertions #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 12
) (
  // clock, reset, bus
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire cbq_pkg::cbq_wb_req_t wb_req_i,
  input wire cbq_pkg::cbq_wb_rsp_t wb_rsp_o,
  // observed design
  input wire logic [DATA_W-1:0]    sample_i,
  input wire logic                 trigger_i,
  input wire logic                 qual_i,
  // capture side
  input wire logic                 mem_we_o,
  input wire logic [ADDR_W-1:0]    mem_addr_o,
  input wire logic [DATA_W:0]      mem_data_o,
  input wire logic                 busy_o,
  input wire logic                 done_o,
  input wire logic                 seg_trig_o
);
  logic [31:0]       cfg;
  logic [DATA_W-1:0] mask;
  logic              wr_ok;
  // shadow settings; writes while busy are dropped by the slave
  assign wr_ok = wb_rsp_o.ack && wb_req_i.we && !busy_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg  <= cbq_pkg::CFG_RESET;
      mask <= '0;
    end else if (wr_ok && wb_req_i.adr == cbq_pkg::ADDR_CONFIG) begin
      cfg <= wb_req_i.dat;
    end else if (wr_ok && wb_req_i.adr == cbq_pkg::ADDR_INSPECT) begin
      mask <= DATA_W'(wb_req_i.dat);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  store_data_a: assert property (
    mem_we_o |-> mem_data_o[DATA_W-1:0] == $past(sample_i))
    else $error("stored word is not the sampled one");
  addr_step_a: assert property (
    mem_we_o && $past(mem_we_o) && !cfg[0]
      |-> mem_addr_o == $past(mem_addr_o) + 1'b1)
    else $error("write address did not step circularly");
  every_cycle_a: assert property (
    busy_o && $past(busy_o) && $past(busy_o, 2)
      && (cfg[0] || cfg[6:4] == 3'h0) |-> mem_we_o)
    else $error("unqualified cycle not stored");
  inport_a: assert property (
    mem_we_o && !cfg[0] && cfg[6:4] == 3'h1 |-> $past(qual_i))
    else $error("stored while qualifier input low");
  trans_a: assert property (
    mem_we_o && !cfg[0] && cfg[6:4] == 3'h2
      |-> (($past(sample_i) ^ $past(sample_i, 2)) & mask) != '0)
    else $error("stored without inspected change");
  trig_pulse_a: assert property (seg_trig_o |=> !seg_trig_o)
    else $error("segment trigger pulse too long");
  trig_cause_a: assert property (seg_trig_o |-> $past(trigger_i))
    else $error("segment trigger without trigger input");
  done_idle_a: assert property (done_o |-> !busy_o && !seg_trig_o)
    else $error("done while acquisition running");
  cover property (seg_trig_o);
  cover property ($rose(done_o));
  cover property (mem_we_o && mem_data_o[DATA_W]);
endmodule // cbq_capture_assertions
bind cbq_capture cbq_capture_assertions #(
  .DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .sample_i(sample_i), .trigger_i(trigger_i), .qual_i(qual_i),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
  .busy_o(busy_o), .done_o(done_o), .seg_trig_o(seg_trig_o));
`default_nettype wire

// >>> sim/cbq_observed_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbq_observed_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // event request from the bench
  input  wire logic        fire_i,
  // observed signals
  output logic [31:0]      sample_o,
  output logic             trigger_o,
  output logic             qual_o
);
  // counting data makes every stored word predictable
  // qualifier changes after edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o  <= 32'h0;
      trigger_o <= 1'h0;
      qual_o    <= 1'h0;
    end else begin
      sample_o  <= sample_o + 32'h1;
      trigger_o <= fire_i;
      qual_o    <= sample_o[1];
    end
  end
endmodule // cbq_observed_model
`default_nettype wire

// >>> sim/test_capture_buffer_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp); \
  end \
end
module test_capture_buffer_qualifier;
  logic                 clk_i, rst_i, fire, trig, qual, seen, prev_we;
  logic                 mem_we_o, busy_o, done_o, seg_trig_o;
  logic [31:0]          smp, rd;
  logic [11:0]          mem_addr_o;
  logic [32:0]          mem_data_o;
  cbq_pkg::cbq_wb_req_t req;
  cbq_pkg::cbq_wb_rsp_t rsp;
  int                   err_count, samples_checked, post_n, seg_n;
  int                   post_tab[3] = '{3584, 2048, 512};
  cbq_capture u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .sample_i(smp), .trigger_i(trig), .qual_i(qual),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .busy_o(busy_o), .done_o(done_o), .seg_trig_o(seg_trig_o));
  cbq_observed_model u_far (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .sample_o(smp), .trigger_o(trig), .qual_o(qual));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (seg_trig_o) begin
      post_n <= 0;
      seg_n  <= seg_n + 1;
    end else if (mem_we_o) begin
      post_n <= post_n + 1;
    end
    if (mem_we_o && seen) `CHK(mem_data_o[32], !prev_we)
    if (mem_we_o) seen <= 1'h1;
    prev_we <= mem_we_o;
  end
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc:1'h1, stb:1'h1, we:we, sel:4'hF, adr:a, dat:d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'h1 && n < 50);
    rd = rsp.dat;
    req <= '0;
    if (n >= 50) `CHK(1'h0, 1'h1)
  endtask
  // one acquisition; idle gaps before each trigger let the buffer wrap in the modes that store every cycle
  task automatic run(input logic [31:0] cfg, input logic [1:0] tp,
                     input int trigs, input int exp_post);
    int n;
    seen = 1'h0;
    post_n = 0;
    seg_n = 0;
    xfer(1'h1, cbq_pkg::ADDR_CONFIG, cfg);
    xfer(1'h1, cbq_pkg::ADDR_TRIGPOS, {30'h0, tp});
    xfer(1'h0, cbq_pkg::ADDR_CONFIG, 32'h0);
    `CHK(rd, cfg)
    xfer(1'h1, cbq_pkg::ADDR_CTRL, 32'h1);
    repeat (trigs) begin
      repeat (cfg[0] ? 100 : 4200) @(posedge clk_i);
      fire <= 1'h1;
      @(posedge clk_i);
      fire <= 1'h0;
    end
    for (n = 0; n < 20000 && done_o !== 1'h1; n++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    `CHK(done_o, 1'h1)
    `CHK(post_n, exp_post)
    `CHK(seg_n, trigs)
    xfer(1'h0, cbq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h8)
    `CHK(busy_o, 1'h0)
    xfer(1'h0, cbq_pkg::ADDR_SEGIDX, 32'h0);
    `CHK(rd, trigs - 1)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_count++;
    report_and_stop;
  end
  initial begin
    {fire, rst_i, seen, prev_we} = 4'h4;
    req = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    xfer(1'h0, cbq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h1)
    xfer(1'h0, cbq_pkg::ADDR_CONFIG, 32'h0);
    `CHK(rd, cbq_pkg::CFG_RESET)
    xfer(1'h0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    xfer(1'h1, cbq_pkg::ADDR_INSPECT, 32'h4);
    for (int q = 0; q < 6; q++) begin
      run(32'h2 | (q << 4), 2'(q % 3), 1, post_tab[q % 3]);
    end
    $display("test qualifier modes done");
    run(32'h613, 2'h2, 64, 8);
    $display("test segmented done");
    seen = 1'h0;
    xfer(1'h1, cbq_pkg::ADDR_CONFIG, 32'h0);
    xfer(1'h1, cbq_pkg::ADDR_CTRL, 32'h1);
    xfer(1'h0, cbq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h2)
    `CHK(busy_o, 1'h1)
    xfer(1'h1, cbq_pkg::ADDR_CTRL, 32'h2);
    xfer(1'h0, cbq_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h1)
    $display("test abort done");
    report_and_stop;
  end
endmodule // test_capture_buffer_qualifier
`default_nettype wire
